/* File: dv/sar_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Fetch and load/store side
// ------------------------------------------------------------
module sar_core_model
(
    // Clock
    input wire logic clk_i,
    // Next access from the bench
    input wire logic [43:0] cmd_i,
    // Access towards the resolver
    output logic [43:0] acc_o
);
    // Launched just after the edge, as the pipeline does
    always_ff @(posedge clk_i)
    begin
        acc_o <= cmd_i;
    end
endmodule
`default_nettype wire

/* File: dv/storage_attribute_resolver_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module storage_attribute_resolver_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pad = 12'h000;
    logic [31:0] pwd = 32'h0000_0000;
    logic [43:0] cmd = 44'h000_0000_0000;
    logic [43:0] acc;
    logic [31:0] prd;
    logic prdy, perr, wt, cc, gd, us, le, lu, la, mw, bp, fh, pe, dsi, er;
    logic [31:0] rd;
    int bad_count = 0;
    int n_compared = 0;

    always #50 clk = ~clk;

    sar_core_model i_core (.clk_i(clk), .cmd_i(cmd), .acc_o(acc));

    sar_resolver i_dut (.CLK_I(clk), .RESETN_I(rst_n), .CE_I(1'b1), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pad), .PWDATA_I(pwd), .PSTRB_I(4'hF),
        .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .ACC_VALID_I(acc[43]),
        .ACC_FETCH_I(acc[42]), .ACC_STORE_I(acc[41]), .EFFECTIVE_ADDR_I(acc[40:9]),
        .INSTR_RELOCATE_BIT_I(acc[8]), .CACHE_HIT_I(acc[7]), .PRIOR_DONE_I(acc[6]),
        .TLB_WRITETHRU_I(acc[5]), .TLB_INHIBIT_I(acc[4]), .TLB_COHERENT_I(acc[3]),
        .TLB_GUARDED_I(acc[2]), .TLB_USER_I(acc[1]), .TLB_LITTLE_I(acc[0]),
        .WRITETHRU_O(wt), .CACHEABLE_O(cc), .GUARDED_O(gd), .USER_ATTR_O(us),
        .LITTLE_ENDIAN_O(le), .LINE_UPDATE_O(lu), .LINE_ALLOC_O(la), .MEM_WRITE_O(mw),
        .BYPASS_O(bp), .FETCH_HOLD_O(fh), .PREFETCH_EN_O(pe), .DSI_O(dsi));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chk(input string nm, input logic seen, input logic exp);
        check(nm, {31'h0000_0000, seen}, {31'h0000_0000, exp});
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge clk);
        end
        while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // k is {fetch, store}, m is {relocate, hit, prior done}
    task automatic go(input logic [1:0] k, input logic [31:0] adr, input logic [2:0] m,
                      input logic [5:0] t);
        @(posedge clk);
        cmd <= {1'b1, k, adr, m, t};
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && n_compared > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_reset();
        apb(1'b0, sar_pkg::OFF_WRITETHRU, 32'h0000_0000);
        check("writethru reg", rd, 32'h0000_0000);
        apb(1'b0, sar_pkg::OFF_DCACHEABLE, 32'h0000_0000);
        check("dcacheable reg", rd, 32'h0000_0000);
        apb(1'b0, sar_pkg::OFF_GUARDED, 32'h0000_0000);
        check("guarded reg", rd, 32'hFFFF_FFFF);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk("unmapped error", er, 1'b1);
        go(2'b10, 32'h3000_0000, 3'b000, 6'h00);
        chk("real guarded hold", fh, 1'b1);
        chk("real guarded", gd, 1'b1);
    endtask

    task automatic t_region();
        logic [31:0] r;
        logic [31:0] adr [4];
        logic [3:0] hit_map;
        r = 32'h8000_0001;
        adr = '{32'h0000_0000, 32'h07FF_FFFF, 32'h0800_0000, 32'hF800_0000};
        // Regions 0, 0, 1 and 31 against bits 0 and 31 set
        hit_map = 4'b1011;
        apb(1'b1, sar_pkg::OFF_DCACHEABLE, r);
        apb(1'b0, sar_pkg::OFF_DCACHEABLE, 32'h0000_0000);
        check("dcacheable rb", rd, r);
        for (int i = 0; i < 4; i++)
        begin
            // Page inhibit set on purpose: real mode must not see it
            go(2'b00, adr[i], 3'b000, 6'h10);
            chk("real cacheable", cc, hit_map[i]);
        end
        apb(1'b1, sar_pkg::OFF_ENDIAN, 32'h0000_0004);
        go(2'b00, 32'h1000_0000, 3'b000, 6'h00);
        chk("real little", le, 1'b1);
        go(2'b10, 32'h0000_0000, 3'b000, 6'h00);
        chk("instr cacheable", cc, 1'b0);
        go(2'b00, 32'h0800_0000, 3'b100, 6'h00);
        chk("virtual cacheable", cc, 1'b1);
        go(2'b00, 32'h5000_0000, 3'b100, 6'h10);
        chk("inhibit cacheable", cc, 1'b0);
        chk("inhibit bypass", bp, 1'b1);
    endtask

    task automatic t_policy();
        for (int i = 0; i < 4; i++)
        begin
            go(2'b01, 32'h1000_0000, {1'b1, i[0], 1'b1}, {i[1], 5'h00});
            chk("line update", lu, !(i[1] && !i[0]));
            chk("line alloc", la, !i[1] && !i[0]);
            chk("mem write", mw, i[1]);
            chk("writethru", wt, i[1]);
        end
        for (int i = 0; i < 4; i++)
        begin
            go(2'b01, 32'h2000_0000, 3'b111, {2'b00, i[1], 2'b00, i[0]});
            chk("little", le, i[0]);
            chk("coherent mem", mw, 1'b0);
            chk("coherent line", lu, 1'b1);
        end
    endtask

    task automatic t_guard_user();
        go(2'b10, 32'h4000_0000, 3'b100, 6'h04);
        chk("guarded hold", fh, 1'b1);
        chk("prefetch off", pe, 1'b0);
        go(2'b10, 32'h4000_0000, 3'b101, 6'h04);
        chk("hold released", fh, 1'b0);
        go(2'b10, 32'h4000_0000, 3'b100, 6'h00);
        chk("prefetch on", pe, 1'b1);
        chk("unguarded", gd, 1'b0);
        apb(1'b1, sar_pkg::OFF_CORECFG, 32'h0000_0001);
        go(2'b01, 32'h6000_0000, 3'b100, 6'h02);
        chk("user dsi", dsi, 1'b1);
        chk("user inert", us, 1'b0);
        apb(1'b0, sar_pkg::OFF_FAULTADDR, 32'h0000_0000);
        check("fault addr", rd, 32'h6000_0000);
        apb(1'b1, sar_pkg::OFF_CORECFG, 32'h0000_0000);
        go(2'b01, 32'h6000_0000, 3'b100, 6'h02);
        chk("user no dsi", dsi, 1'b0);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_region();
        t_policy();
        t_guard_user();
        print_verdict();
    end

    // Whole run is about a hundred cycles
    initial
    begin
        #(100 * 20000);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: rtl/sar_access_policy.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_access_policy
(
    // Access
    input wire logic valid_i,
    input wire logic fetch_i,
    input wire logic store_i,
    input wire logic cache_hit_i,
    input wire logic prior_done_i,
    // Configuration
    input wire logic user_store_exc_enable_i,
    input wire logic user_impl_i,
    sar_attr_if.sink attr_i,
    // Decisions
    output logic line_update_o,
    output logic line_alloc_o,
    output logic mem_write_o,
    output logic bypass_o,
    output logic fetch_hold_o,
    output logic prefetch_en_o,
    output logic dsi_o,
    output logic user_attr_o
);
    logic cst;
    // The coherent field is deliberately left unread: it steers nothing
    assign cst = valid_i && store_i && attr_i.attr.cacheable;
    assign line_update_o = cst && (cache_hit_i || !attr_i.attr.wt);
    assign line_alloc_o = cst && !cache_hit_i && !attr_i.attr.wt;
    assign mem_write_o = valid_i && store_i && (attr_i.attr.wt || !attr_i.attr.cacheable);
    assign bypass_o = valid_i && !attr_i.attr.cacheable;
    assign fetch_hold_o = valid_i && fetch_i && attr_i.attr.guarded && !prior_done_i;
    assign prefetch_en_o = !attr_i.attr.guarded;
    assign dsi_o = valid_i && store_i && attr_i.attr.user && user_store_exc_enable_i;
    // Without user behaviour the attribute is hidden from fetch and load paths
    assign user_attr_o = attr_i.attr.user && user_impl_i;
endmodule
`default_nettype wire

/* File: rtl/sar_attr_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sar_attr_if;
    sar_pkg::sar_attr_t attr;
    modport src (output attr);
    modport sink (input attr);
endinterface
`default_nettype wire

/* File: rtl/sar_pkg.sv */
package sar_pkg;

    // ------------------------------------------------------------
    // Widths and region indexing
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned REGION_W = 5;
    localparam int unsigned REGION_MSB = 31;
    localparam int unsigned REGION_LSB = 27;
    localparam logic [4:0] REGION_LAST = 5'h1F;
    localparam int unsigned NUM_ATTR_REGS = 6;
    localparam int unsigned COUNT_W = 16;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_WRITETHRU = 12'h000;
    localparam logic [11:0] OFF_DCACHEABLE = 12'h004;
    localparam logic [11:0] OFF_ICACHEABLE = 12'h008;
    localparam logic [11:0] OFF_GUARDED = 12'h00C;
    localparam logic [11:0] OFF_USERDEF = 12'h010;
    localparam logic [11:0] OFF_ENDIAN = 12'h014;
    localparam logic [11:0] OFF_CORECFG = 12'h018;
    localparam logic [11:0] OFF_STATUS = 12'h01C;
    localparam logic [11:0] OFF_FAULTADDR = 12'h020;

    // Index of each attribute register in the storage array
    localparam logic [2:0] IDX_WRITETHRU = 3'h0;
    localparam logic [2:0] IDX_DCACHEABLE = 3'h1;
    localparam logic [2:0] IDX_ICACHEABLE = 3'h2;
    localparam logic [2:0] IDX_GUARDED = 3'h3;
    localparam logic [2:0] IDX_USERDEF = 3'h4;
    localparam logic [2:0] IDX_ENDIAN = 3'h5;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [31:0] RST_ZEROS = 32'h0000_0000;
    localparam logic [31:0] RST_ONES = 32'hFFFF_FFFF;
    localparam int unsigned CFG_USER_EXC_BIT = 0;
    localparam int unsigned CFG_USER_IMPL_BIT = 1;
    localparam logic [31:0] CFG_WR_MASK = 32'h0000_0003;
    localparam int unsigned STAT_MODE_BIT = 16;

    typedef enum logic [1:0] {
        SAR_APB_IDLE = 2'b01,
        SAR_APB_ACCESS = 2'b10
    } sar_apb_state_t;

    typedef struct packed {
        logic wt;
        logic cacheable;
        logic coherent;
        logic guarded;
        logic user;
        logic little;
    } sar_attr_t;

    // Region bit of a 32-bit attribute register for an address
    function automatic logic region_bit(input logic [31:0] r, input logic [31:0] addr);
        return r[addr[REGION_MSB:REGION_LSB]];
    endfunction

    // Byte-lane merge of write data
    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] attr_reset(input logic [2:0] idx);
        return (idx == IDX_GUARDED) ? RST_ONES : RST_ZEROS;
    endfunction

endpackage

/* File: rtl/sar_region_select.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_region_select
(
    // Access
    input wire logic [31:0] effective_addr_i,
    input wire logic instr_relocate_bit_i,
    input wire logic fetch_i,
    // Real-mode registers
    input wire logic [31:0] data_writethru_reg_i,
    input wire logic [31:0] data_cacheable_reg_i,
    input wire logic [31:0] instr_cacheable_reg_i,
    input wire logic [31:0] guarded_region_reg_i,
    input wire logic [31:0] user_defined_reg_i,
    input wire logic [31:0] endian_reg_i,
    // Page entry attributes, cacheable already inverted from inhibit
    input wire sar_pkg::sar_attr_t tlb_attr_i,
    // Resolved set
    sar_attr_if.src attr_o
);
    always_comb
    begin
        if (instr_relocate_bit_i)
        begin
            attr_o.attr = tlb_attr_i;
        end
        else
        begin
            // Real mode has no coherency control at all
            attr_o.attr.coherent = 1'b0;
            attr_o.attr.wt = sar_pkg::region_bit(data_writethru_reg_i, effective_addr_i);
            attr_o.attr.cacheable = fetch_i
                ? sar_pkg::region_bit(instr_cacheable_reg_i, effective_addr_i)
                : sar_pkg::region_bit(data_cacheable_reg_i, effective_addr_i);
            attr_o.attr.guarded = sar_pkg::region_bit(guarded_region_reg_i, effective_addr_i);
            attr_o.attr.user = sar_pkg::region_bit(user_defined_reg_i, effective_addr_i);
            attr_o.attr.little = sar_pkg::region_bit(endian_reg_i, effective_addr_i);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/sar_resolver.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Write-back hit updates line, not memory
// - Write-back miss allocates line, no memory update
// - Write-through hit updates line and memory
// - Write-through miss updates memory, no allocation
// - Virtual mode: inhibit 0 cacheable, 1 bypass
// - Real mode cacheable bit 1 enables caching
// - Coherency attribute changes nothing
// - Unguarded regions allow speculative access
// - Guarded fetch waits for earlier instructions
// - Guarded regions get no instruction prefetch
// - Enabled store to user region raises fault
// - Disabled enable never raises store fault
// - User attribute inert unless behaviour implemented
// - Endian attribute 0 big, 1 little
// - Virtual mode ignores real-mode registers
// - 32-bit registers, bit per 128 MB region
// - Top five address bits pick region bit
// - Relocate bit selects page or register attributes
// - Guarded register resets to all ones
// - Data cacheable register resets to zero
// - Write-through register resets to zero
module sar_resolver
(
    // Clock, reset, enable
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Access request from fetch and load/store units
    input wire logic ACC_VALID_I,
    input wire logic ACC_FETCH_I,
    input wire logic ACC_STORE_I,
    input wire logic [31:0] EFFECTIVE_ADDR_I,
    input wire logic INSTR_RELOCATE_BIT_I,
    input wire logic CACHE_HIT_I,
    input wire logic PRIOR_DONE_I,
    // Page entry attributes
    input wire logic TLB_WRITETHRU_I,
    input wire logic TLB_INHIBIT_I,
    input wire logic TLB_COHERENT_I,
    input wire logic TLB_GUARDED_I,
    input wire logic TLB_USER_I,
    input wire logic TLB_LITTLE_I,
    // Resolved attributes
    output logic WRITETHRU_O,
    output logic CACHEABLE_O,
    output logic GUARDED_O,
    output logic USER_ATTR_O,
    output logic LITTLE_ENDIAN_O,
    // Access decisions
    output logic LINE_UPDATE_O,
    output logic LINE_ALLOC_O,
    output logic MEM_WRITE_O,
    output logic BYPASS_O,
    output logic FETCH_HOLD_O,
    output logic PREFETCH_EN_O,
    output logic DSI_O
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] attr_reg [sar_pkg::NUM_ATTR_REGS];
    logic [31:0] core_config_reg;
    logic [15:0] dsi_count;
    logic [31:0] fault_addr;
    logic write_seen;
    sar_pkg::sar_apb_state_t apb_state;
    sar_pkg::sar_attr_t tlb_attr;
    sar_attr_if attr_bus ();

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic dec_hit;
    logic dec_attr;
    logic dec_cfg;
    logic [2:0] dec_idx;
    logic [31:0] rd_val;
    logic apb_write;
    logic [31:0] status_val;

    always_comb
    begin
        dec_hit = 1'b1;
        dec_attr = 1'b0;
        dec_cfg = 1'b0;
        dec_idx = sar_pkg::IDX_WRITETHRU;
        if (PADDR_I == sar_pkg::OFF_WRITETHRU)
        begin
            dec_attr = 1'b1;
            dec_idx = sar_pkg::IDX_WRITETHRU;
        end
        else if (PADDR_I == sar_pkg::OFF_DCACHEABLE)
        begin
            dec_attr = 1'b1;
            dec_idx = sar_pkg::IDX_DCACHEABLE;
        end
        else if (PADDR_I == sar_pkg::OFF_ICACHEABLE)
        begin
            dec_attr = 1'b1;
            dec_idx = sar_pkg::IDX_ICACHEABLE;
        end
        else if (PADDR_I == sar_pkg::OFF_GUARDED)
        begin
            dec_attr = 1'b1;
            dec_idx = sar_pkg::IDX_GUARDED;
        end
        else if (PADDR_I == sar_pkg::OFF_USERDEF)
        begin
            dec_attr = 1'b1;
            dec_idx = sar_pkg::IDX_USERDEF;
        end
        else if (PADDR_I == sar_pkg::OFF_ENDIAN)
        begin
            dec_attr = 1'b1;
            dec_idx = sar_pkg::IDX_ENDIAN;
        end
        else if (PADDR_I == sar_pkg::OFF_CORECFG)
        begin
            dec_cfg = 1'b1;
        end
        else if (PADDR_I != sar_pkg::OFF_STATUS && PADDR_I != sar_pkg::OFF_FAULTADDR)
        begin
            dec_hit = 1'b0;
        end
    end

    always_comb
    begin
        status_val = sar_pkg::RST_ZEROS;
        status_val[15:0] = dsi_count;
        status_val[sar_pkg::STAT_MODE_BIT] = INSTR_RELOCATE_BIT_I;
    end

    always_comb
    begin
        if (dec_attr)
        begin
            rd_val = attr_reg[dec_idx];
        end
        else if (dec_cfg)
        begin
            rd_val = core_config_reg;
        end
        else if (PADDR_I == sar_pkg::OFF_STATUS)
        begin
            rd_val = status_val;
        end
        else if (PADDR_I == sar_pkg::OFF_FAULTADDR)
        begin
            rd_val = fault_addr;
        end
        else
        begin
            rd_val = sar_pkg::RST_ZEROS;
        end
    end

    // Write lands at the edge that sees pready with psel and penable
    assign apb_write = (apb_state == sar_pkg::SAR_APB_ACCESS) && PSEL_I && PENABLE_I
                       && PWRITE_I && dec_hit;

    // ------------------------------------------------------------
    // APB handshake: one wait-free access phase
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            apb_state <= sar_pkg::SAR_APB_IDLE;
            PREADY_O <= 1'b0;
            PRDATA_O <= sar_pkg::RST_ZEROS;
            PSLVERR_O <= 1'b0;
        end
        else if (CE_I)
        begin
            case (apb_state)
                sar_pkg::SAR_APB_IDLE:
                begin
                    if (PSEL_I && !PENABLE_I)
                    begin
                        apb_state <= sar_pkg::SAR_APB_ACCESS;
                        PREADY_O <= 1'b1;
                        PRDATA_O <= PWRITE_I ? sar_pkg::RST_ZEROS : rd_val;
                        PSLVERR_O <= !dec_hit;
                    end
                end
                sar_pkg::SAR_APB_ACCESS:
                begin
                    if (PSEL_I && PENABLE_I)
                    begin
                        apb_state <= sar_pkg::SAR_APB_IDLE;
                        PREADY_O <= 1'b0;
                        PRDATA_O <= sar_pkg::RST_ZEROS;
                        PSLVERR_O <= 1'b0;
                    end
                end
                default:
                begin
                    apb_state <= sar_pkg::SAR_APB_IDLE;
                    PREADY_O <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Attribute and configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            for (int i = 0; i < sar_pkg::NUM_ATTR_REGS; i++)
            begin
                attr_reg[i] <= sar_pkg::attr_reset(3'(i));
            end
            core_config_reg <= sar_pkg::RST_ZEROS;
        end
        else if (CE_I && apb_write)
        begin
            if (dec_attr)
            begin
                attr_reg[dec_idx] <= sar_pkg::apply_strb(attr_reg[dec_idx], PWDATA_I, PSTRB_I);
            end
            else if (dec_cfg)
            begin
                core_config_reg <= sar_pkg::apply_strb(core_config_reg, PWDATA_I, PSTRB_I)
                                   & sar_pkg::CFG_WR_MASK;
            end
        end
    end

    // Fault log: count wraps, address holds the latest faulting store
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            dsi_count <= 16'h0000;
            fault_addr <= sar_pkg::RST_ZEROS;
        end
        else if (CE_I && DSI_O)
        begin
            dsi_count <= dsi_count + 16'h0001;
            fault_addr <= EFFECTIVE_ADDR_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            write_seen <= 1'b0;
        end
        else if (CE_I && apb_write)
        begin
            write_seen <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Resolution path, combinational so the answer is same-cycle
    // ------------------------------------------------------------
    always_comb
    begin
        tlb_attr.wt = TLB_WRITETHRU_I;
        tlb_attr.cacheable = !TLB_INHIBIT_I;
        tlb_attr.coherent = TLB_COHERENT_I;
        tlb_attr.guarded = TLB_GUARDED_I;
        tlb_attr.user = TLB_USER_I;
        tlb_attr.little = TLB_LITTLE_I;
    end

    sar_region_select u_select
    (
        .effective_addr_i(EFFECTIVE_ADDR_I),
        .instr_relocate_bit_i(INSTR_RELOCATE_BIT_I),
        .fetch_i(ACC_FETCH_I),
        .data_writethru_reg_i(attr_reg[sar_pkg::IDX_WRITETHRU]),
        .data_cacheable_reg_i(attr_reg[sar_pkg::IDX_DCACHEABLE]),
        .instr_cacheable_reg_i(attr_reg[sar_pkg::IDX_ICACHEABLE]),
        .guarded_region_reg_i(attr_reg[sar_pkg::IDX_GUARDED]),
        .user_defined_reg_i(attr_reg[sar_pkg::IDX_USERDEF]),
        .endian_reg_i(attr_reg[sar_pkg::IDX_ENDIAN]),
        .tlb_attr_i(tlb_attr),
        .attr_o(attr_bus)
    );

    sar_access_policy u_policy
    (
        .valid_i(ACC_VALID_I),
        .fetch_i(ACC_FETCH_I),
        .store_i(ACC_STORE_I),
        .cache_hit_i(CACHE_HIT_I),
        .prior_done_i(PRIOR_DONE_I),
        .user_store_exc_enable_i(core_config_reg[sar_pkg::CFG_USER_EXC_BIT]),
        .user_impl_i(core_config_reg[sar_pkg::CFG_USER_IMPL_BIT]),
        .attr_i(attr_bus),
        .line_update_o(LINE_UPDATE_O),
        .line_alloc_o(LINE_ALLOC_O),
        .mem_write_o(MEM_WRITE_O),
        .bypass_o(BYPASS_O),
        .fetch_hold_o(FETCH_HOLD_O),
        .prefetch_en_o(PREFETCH_EN_O),
        .dsi_o(DSI_O),
        .user_attr_o(USER_ATTR_O)
    );

    assign WRITETHRU_O = attr_bus.attr.wt;
    assign CACHEABLE_O = attr_bus.attr.cacheable;
    assign GUARDED_O = attr_bus.attr.guarded;
    assign LITTLE_ENDIAN_O = attr_bus.attr.little;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    logic st_c;
    assign st_c = ACC_VALID_I && ACC_STORE_I && CACHEABLE_O;

    wb_hit_a: assert property (st_c && !WRITETHRU_O && CACHE_HIT_I |-> LINE_UPDATE_O && !MEM_WRITE_O)
        else $error("write-back hit touched memory");
    wb_miss_a: assert property (st_c && !WRITETHRU_O && !CACHE_HIT_I
                                |-> LINE_ALLOC_O && LINE_UPDATE_O && !MEM_WRITE_O)
        else $error("write-back miss did not allocate");
    wt_hit_a: assert property (st_c && WRITETHRU_O && CACHE_HIT_I |-> LINE_UPDATE_O && MEM_WRITE_O)
        else $error("write-through hit missed a target");
    wt_miss_a: assert property (st_c && WRITETHRU_O && !CACHE_HIT_I |-> MEM_WRITE_O && !LINE_ALLOC_O)
        else $error("write-through miss allocated");
    virt_attr_a: assert property (INSTR_RELOCATE_BIT_I |-> CACHEABLE_O == !TLB_INHIBIT_I
                                  && LITTLE_ENDIAN_O == TLB_LITTLE_I && GUARDED_O == TLB_GUARDED_I)
        else $error("virtual attributes not from page entry");
    real_cache_a: assert property (!INSTR_RELOCATE_BIT_I && !ACC_FETCH_I
                                   |-> CACHEABLE_O == sar_pkg::region_bit(
                                       attr_reg[sar_pkg::IDX_DCACHEABLE], EFFECTIVE_ADDR_I))
        else $error("real-mode cacheability wrong");
    top_region_a: assert property (!INSTR_RELOCATE_BIT_I
                                   && EFFECTIVE_ADDR_I[31:27] == sar_pkg::REGION_LAST
                                   |-> GUARDED_O == attr_reg[sar_pkg::IDX_GUARDED][31])
        else $error("top region not on bit 31");
    guard_hold_a: assert property (ACC_VALID_I && ACC_FETCH_I && GUARDED_O && !PRIOR_DONE_I
                                   |-> FETCH_HOLD_O && !PREFETCH_EN_O)
        else $error("guarded fetch not held");
    guard_pref_a: assert property (PREFETCH_EN_O == !GUARDED_O)
        else $error("prefetch enable wrong");
    user_dsi_a: assert property (ACC_VALID_I && ACC_STORE_I
                                 |-> DSI_O == (attr_bus.attr.user
                                               && core_config_reg[sar_pkg::CFG_USER_EXC_BIT]))
        else $error("user store fault wrong");
    reset_val_a: assert property (!write_seen |-> attr_reg[sar_pkg::IDX_GUARDED] == sar_pkg::RST_ONES
                                  && attr_reg[sar_pkg::IDX_DCACHEABLE] == sar_pkg::RST_ZEROS
                                  && attr_reg[sar_pkg::IDX_WRITETHRU] == sar_pkg::RST_ZEROS)
        else $error("reset value lost without a write");
    apb_ready_a: assert property (CE_I && PSEL_I && !PENABLE_I && apb_state == sar_pkg::SAR_APB_IDLE
                                  |=> PREADY_O)
        else $error("pready late");

    dsi_c: cover property (DSI_O);
    hold_c: cover property (FETCH_HOLD_O ##1 !FETCH_HOLD_O);
    wtmiss_c: cover property (st_c && WRITETHRU_O && !CACHE_HIT_I && INSTR_RELOCATE_BIT_I);
    apbwr_c: cover property (apb_write && CE_I && dec_idx == sar_pkg::IDX_GUARDED && dec_attr);

endmodule
`default_nettype wire
